// [verilog/flsw_pkg.sv]
`default_nettype none
package flsw_pkg;
   // flag status bit positions
   localparam int FLSW_BIT_READY     = 7;
   localparam int FLSW_BIT_ERASE_SUS = 6;
   localparam int FLSW_BIT_ERASE_ERR = 5;
   localparam int FLSW_BIT_PROG_ERR  = 4;
   localparam int FLSW_BIT_VPP_ERR   = 3;
   localparam int FLSW_BIT_PROG_SUS  = 2;
   localparam int FLSW_BIT_PROT_ERR  = 1;

   localparam logic [7:0] FLSW_FLAG_STATUS_RESET = 8'h00;
   localparam logic [7:0] FLSW_FLAG_STATUS_MASK  = 8'hFE;
   localparam int         FLSW_SYNC_STAGES       = 2;
   localparam logic [2:0] FLSW_BIT_COUNT_RESET   = 3'h0;

   // instruction opcodes
   localparam logic [7:0] FLSW_WRITE_ENABLE_CMD            = 8'h06;
   localparam logic [7:0] FLSW_WRITE_DISABLE_CMD           = 8'h04;
   localparam logic [7:0] FLSW_READ_FLAGS_CMD              = 8'h70;
   localparam logic [7:0] FLSW_CLEAR_FLAGS_CMD             = 8'h50;
   localparam logic [7:0] FLSW_SUSPEND_CMD                 = 8'h75;
   localparam logic [7:0] FLSW_RESUME_CMD                  = 8'h7A;
   localparam logic [7:0] FLSW_STATUS_WRITE_CMD            = 8'h01;
   localparam logic [7:0] FLSW_LOCK_WRITE_CMD              = 8'hE5;
   localparam logic [7:0] FLSW_OTP_PROGRAM_CMD             = 8'h42;
   localparam logic [7:0] FLSW_PAGE_PROGRAM_CMD            = 8'h02;
   localparam logic [7:0] FLSW_DUAL_FAST_PROGRAM_CMD       = 8'hA2;
   localparam logic [7:0] FLSW_DUAL_EXT_FAST_PROGRAM_CMD   = 8'hD2;
   localparam logic [7:0] FLSW_QUAD_FAST_PROGRAM_CMD       = 8'h32;
   localparam logic [7:0] FLSW_QUAD_EXT_FAST_PROGRAM_CMD   = 8'h12;
   localparam logic [7:0] FLSW_SUBSECTOR_ERASE_CMD         = 8'h20;
   localparam logic [7:0] FLSW_SECTOR_ERASE_CMD            = 8'hD8;
   localparam logic [7:0] FLSW_BULK_ERASE_CMD              = 8'hC7;
   localparam logic [7:0] FLSW_NONVOLATILE_CONFIG_WRITE_CMD = 8'hB1;

   typedef enum logic [2:0] {
      FLSW_OP_NONE,
      FLSW_OP_PROGRAM,
      FLSW_OP_OTP,
      FLSW_OP_ERASE,
      FLSW_OP_STATUS_WR,
      FLSW_OP_LOCK_WR,
      FLSW_OP_NVCR_WR
   } flsw_op_t;

   // protection verdicts from the lock and block-protect decoders
   typedef struct packed {
      logic sectorLockProtection;
      logic blockProtectProtection;
      logic otpLocked;
      logic statusWriteDisable;
   } flsw_prot_t;

   // one-cycle reports from the array engine
   typedef struct packed {
      logic done;
      logic verifyFail;
      logic oneOverZero;
      logic patternMul64;
   } flsw_eng_t;

   // what starts the array engine
   typedef struct packed {
      logic     start;
      flsw_op_t kind;
   } flsw_req_t;
endpackage
`default_nettype wire

// [verilog/flsw_sync.sv]
`default_nettype none
module flsw_sync
   import flsw_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1_reg <= '0;
         syncOut    <= '0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut    <= stage1_reg;
      end
   end
endmodule
`default_nettype wire

// [verilog/flsw_shifter.sv]
`default_nettype none
module flsw_shifter
   import flsw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       selected,
   input  wire logic       sclkRise,
   input  wire logic       dataIn,
   output logic      [7:0] byteOut,
   output logic            byteValid,
   output logic            firstByte,
   output logic            wholeBytes
);
   logic [2:0] bitCount_reg;
   logic [6:0] shift_reg;
   logic       opcodeDone_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bitCount_reg   <= FLSW_BIT_COUNT_RESET;
         shift_reg      <= 7'h00;
         byteOut        <= 8'h00;
         byteValid      <= 1'b0;
         firstByte      <= 1'b0;
         opcodeDone_reg <= 1'b0;
      end else if (!selected) begin
         bitCount_reg   <= FLSW_BIT_COUNT_RESET;
         byteValid      <= 1'b0;
         opcodeDone_reg <= 1'b0;
      end else begin
         byteValid <= 1'b0;
         if (sclkRise) begin
            bitCount_reg <= bitCount_reg + 3'h1;
            shift_reg    <= {shift_reg[5:0], dataIn};
            if (bitCount_reg == 3'h7) begin
               byteOut        <= {shift_reg, dataIn};
               byteValid      <= 1'b1;
               firstByte      <= !opcodeDone_reg;
               opcodeDone_reg <= 1'b1;
            end
         end
      end
   end

   assign wholeBytes = (bitCount_reg == FLSW_BIT_COUNT_RESET);
endmodule
`default_nettype wire

// [verilog/flsw_flag_status.sv]
`default_nettype none
module flsw_flag_status
   import flsw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       sclkPin,
   input  wire logic       selectNPin,
   input  wire logic       dataInPin,
   input  wire logic       writeProtectNPin,
   input  wire logic       vppHighPin,
   output logic            dataOut,
   output logic            dataOutOe,
   input  wire logic       twoLineProtocol,
   input  wire logic       fourLineProtocol,
   input  wire logic       initDone,
   input  wire flsw_prot_t prot,
   input  wire flsw_eng_t  eng,
   output flsw_req_t       engReq,
   output logic            writeEnableLatch,
   output logic            writeInProgress,
   output logic      [7:0] flagStatus
);
   typedef enum logic [1:0] {
      FLSW_ST_INIT,
      FLSW_ST_READY,
      FLSW_ST_BUSY
   } flsw_state_t;

   flsw_state_t state_reg;
   flsw_state_t state_next;

   logic [3:0] pinSync;
   logic       sclkSync;
   logic       selectSync;
   logic       selectNSync;
   logic       dataSync;
   logic       vppSync;
   logic       wpNSync;
   logic       sclkPrev_reg;
   logic       selectNPrev_reg;
   logic       sclkRise;
   logic       sclkFall;
   logic       deselect;
   logic [7:0] rxByte;
   logic       rxValid;
   logic       rxFirst;
   logic       wholeBytes;
   logic [7:0] opcode_reg;
   logic       opcodeSeen_reg;
   logic       readFlags_reg;
   logic [7:0] txShift_reg;
   logic       eraseSus_reg;
   logic       progSus_reg;
   logic       eraseErr_reg;
   logic       progErr_reg;
   logic       vppErr_reg;
   logic       protErr_reg;
   logic       vppAtStart_reg;
   flsw_op_t   runKind_reg;
   flsw_op_t   cmdKind;
   logic       cmdBlocked;
   logic       cmdProtHit;
   logic       cmdValid;
   logic       cmdStart;
   logic       cmdProtRefuse;
   logic       clearFlags;
   logic       suspendHit;
   logic       resumeHit;
   logic [7:0] flagsNow;

   // classify an opcode into the modify kind it starts
   function automatic flsw_op_t decodeOp(input logic [7:0] op, input logic multiLine);
      flsw_op_t k;
      k = FLSW_OP_NONE;
      case (op)
         FLSW_PAGE_PROGRAM_CMD:             k = FLSW_OP_PROGRAM;
         FLSW_DUAL_FAST_PROGRAM_CMD,
         FLSW_DUAL_EXT_FAST_PROGRAM_CMD,
         FLSW_QUAD_FAST_PROGRAM_CMD,
         FLSW_QUAD_EXT_FAST_PROGRAM_CMD:    k = multiLine ? FLSW_OP_NONE : FLSW_OP_PROGRAM;
         FLSW_OTP_PROGRAM_CMD:              k = FLSW_OP_OTP;
         FLSW_SUBSECTOR_ERASE_CMD,
         FLSW_SECTOR_ERASE_CMD,
         FLSW_BULK_ERASE_CMD:               k = FLSW_OP_ERASE;
         FLSW_STATUS_WRITE_CMD:             k = FLSW_OP_STATUS_WR;
         FLSW_LOCK_WRITE_CMD:               k = FLSW_OP_LOCK_WR;
         FLSW_NONVOLATILE_CONFIG_WRITE_CMD: k = FLSW_OP_NVCR_WR;
         default:                           k = FLSW_OP_NONE;
      endcase
      return k;
   endfunction

   function automatic logic isProgram(input flsw_op_t k);
      return (k == FLSW_OP_PROGRAM) || (k == FLSW_OP_OTP);
   endfunction

   // pins arrive from the serial clock domain
   // active-low pins inverted so reset zeros match idle, no false edge
   flsw_sync #(
      .WIDTH (4)
   ) u_pinSync (
      .clk     (clk),
      .rstn    (rstn),
      .asyncIn ({sclkPin, dataInPin, vppHighPin, !writeProtectNPin}),
      .syncOut (pinSync)
   );

   flsw_sync #(
      .WIDTH (1)
   ) u_selSync (
      .clk     (clk),
      .rstn    (rstn),
      .asyncIn (!selectNPin),
      .syncOut (selectSync)
   );

   assign sclkSync = pinSync[3];
   assign dataSync = pinSync[2];
   assign vppSync  = pinSync[1];
   assign wpNSync  = !pinSync[0];
   assign selectNSync = !selectSync;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclkPrev_reg    <= 1'b0;
         selectNPrev_reg <= 1'b1;
      end else begin
         sclkPrev_reg    <= sclkSync;
         selectNPrev_reg <= selectNSync;
      end
   end

   assign sclkRise = sclkSync && !sclkPrev_reg && !selectNSync;
   assign sclkFall = !sclkSync && sclkPrev_reg && !selectNSync;
   assign deselect = selectNSync && !selectNPrev_reg;

   flsw_shifter u_shifter (
      .clk        (clk),
      .rstn       (rstn),
      .selected   (!selectNSync),
      .sclkRise   (sclkRise),
      .dataIn     (dataSync),
      .byteOut    (rxByte),
      .byteValid  (rxValid),
      .firstByte  (rxFirst),
      .wholeBytes (wholeBytes)
   );

   // opcode of the current frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         opcode_reg     <= 8'h00;
         opcodeSeen_reg <= 1'b0;
      end else if (deselect) begin
         opcodeSeen_reg <= 1'b0;
      end else if (rxValid && rxFirst) begin
         opcode_reg     <= rxByte;
         opcodeSeen_reg <= 1'b1;
      end
   end

   // commands act at deselect, once the frame is complete
   always_comb begin
      cmdKind    = decodeOp(opcode_reg, twoLineProtocol || fourLineProtocol);
      cmdValid   = deselect && opcodeSeen_reg;
      clearFlags = cmdValid && (opcode_reg == FLSW_CLEAR_FLAGS_CMD);
      suspendHit = cmdValid && (opcode_reg == FLSW_SUSPEND_CMD) && (state_reg == FLSW_ST_BUSY);
      resumeHit  = cmdValid && (opcode_reg == FLSW_RESUME_CMD);
      cmdProtHit = 1'b0;
      cmdBlocked = protErr_reg;
      case (cmdKind)
         FLSW_OP_PROGRAM: begin
            cmdProtHit = prot.sectorLockProtection || prot.blockProtectProtection;
            cmdBlocked = protErr_reg || progErr_reg || vppErr_reg;
         end
         FLSW_OP_OTP: begin
            cmdProtHit = prot.otpLocked;
            cmdBlocked = protErr_reg || progErr_reg || vppErr_reg;
         end
         FLSW_OP_ERASE: begin
            cmdProtHit = prot.sectorLockProtection || prot.blockProtectProtection;
            cmdBlocked = protErr_reg || eraseErr_reg || vppErr_reg;
         end
         FLSW_OP_STATUS_WR: begin
            cmdProtHit = prot.statusWriteDisable && !wpNSync;
         end
         default: begin
            cmdProtHit = 1'b0;
         end
      endcase
      cmdStart = cmdValid && (cmdKind != FLSW_OP_NONE) && wholeBytes && writeEnableLatch
                 && (state_reg == FLSW_ST_READY) && !cmdBlocked && !cmdProtHit;
      cmdProtRefuse = cmdValid && (cmdKind != FLSW_OP_NONE) && wholeBytes && writeEnableLatch
                      && !cmdBlocked && cmdProtHit;
   end

   // controller state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FLSW_ST_INIT: begin
            if (initDone) begin
               state_next = FLSW_ST_READY;
            end
         end
         FLSW_ST_READY: begin
            if (cmdStart) begin
               state_next = FLSW_ST_BUSY;
            end
         end
         FLSW_ST_BUSY: begin
            if (eng.done) begin
               state_next = FLSW_ST_READY;
            end
         end
         default: begin
            state_next = FLSW_ST_INIT;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= FLSW_ST_INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         writeInProgress <= 1'b1;
      end else begin
         writeInProgress <= (state_next != FLSW_ST_READY);
      end
   end

   // engine request, one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         engReq         <= '{start: 1'b0, kind: FLSW_OP_NONE};
         runKind_reg    <= FLSW_OP_NONE;
         vppAtStart_reg <= 1'b0;
      end else begin
         engReq.start <= cmdStart;
         if (cmdStart) begin
            engReq.kind    <= cmdKind;
            runKind_reg    <= cmdKind;
            vppAtStart_reg <= vppSync;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         writeEnableLatch <= 1'b0;
      end else if (cmdValid && wholeBytes) begin
         if (opcode_reg == FLSW_WRITE_ENABLE_CMD) begin
            writeEnableLatch <= 1'b1;
         end else if ((opcode_reg == FLSW_WRITE_DISABLE_CMD) || cmdStart || cmdProtRefuse) begin
            writeEnableLatch <= 1'b0;
         end
      end
   end

   // suspend indicators, device-owned
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eraseSus_reg <= 1'b0;
         progSus_reg  <= 1'b0;
      end else begin
         if (resumeHit) begin
            eraseSus_reg <= 1'b0;
            progSus_reg  <= 1'b0;
         end
         if (suspendHit && (runKind_reg == FLSW_OP_ERASE)) begin
            eraseSus_reg <= 1'b1;
         end
         if (suspendHit && isProgram(runKind_reg)) begin
            progSus_reg <= 1'b1;
         end
      end
   end

   // sticky errors: a set in the clear cycle wins
   // only clear-flags clears
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eraseErr_reg <= 1'b0;
         progErr_reg  <= 1'b0;
         vppErr_reg   <= 1'b0;
         protErr_reg  <= 1'b0;
      end else begin
         if (clearFlags) begin
            eraseErr_reg <= 1'b0;
            progErr_reg  <= 1'b0;
            vppErr_reg   <= 1'b0;
            protErr_reg  <= 1'b0;
         end
         if ((state_reg == FLSW_ST_BUSY) && eng.verifyFail && (runKind_reg == FLSW_OP_ERASE)) begin
            eraseErr_reg <= 1'b1;
         end
         if (cmdProtRefuse && (cmdKind == FLSW_OP_ERASE)) begin
            eraseErr_reg <= 1'b1;
         end
         if ((state_reg == FLSW_ST_BUSY) && eng.verifyFail && isProgram(runKind_reg)) begin
            progErr_reg <= 1'b1;
         end
         if ((state_reg == FLSW_ST_BUSY) && eng.oneOverZero && isProgram(runKind_reg)
             && vppAtStart_reg && vppSync && eng.patternMul64) begin
            progErr_reg <= 1'b1;
         end
         if (cmdProtRefuse && isProgram(cmdKind)) begin
            progErr_reg <= 1'b1;
         end
         if ((state_reg == FLSW_ST_BUSY) && vppAtStart_reg && !vppSync
             && ((runKind_reg == FLSW_OP_ERASE) || isProgram(runKind_reg))) begin
            vppErr_reg <= 1'b1;
         end
         if (cmdProtRefuse) begin
            protErr_reg <= 1'b1;
         end
      end
   end

   // protection error blocks all
   // blocking is in cmdBlocked; the flag already shows the failure

   always_comb begin
      flagsNow                     = FLSW_FLAG_STATUS_RESET;
      flagsNow[FLSW_BIT_READY]     = !writeInProgress;
      flagsNow[FLSW_BIT_ERASE_SUS] = eraseSus_reg;
      flagsNow[FLSW_BIT_ERASE_ERR] = eraseErr_reg;
      flagsNow[FLSW_BIT_PROG_ERR]  = progErr_reg;
      flagsNow[FLSW_BIT_VPP_ERR]   = vppErr_reg;
      flagsNow[FLSW_BIT_PROG_SUS]  = progSus_reg;
      flagsNow[FLSW_BIT_PROT_ERR]  = protErr_reg;
      flagsNow                     = flagsNow & FLSW_FLAG_STATUS_MASK;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flagStatus <= FLSW_FLAG_STATUS_RESET;
      end else begin
         flagStatus <= flagsNow;
      end
   end

   // read-flags: byte repeats while selected so polling needs one opcode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readFlags_reg <= 1'b0;
         txShift_reg   <= 8'h00;
         dataOut       <= 1'b0;
         dataOutOe     <= 1'b0;
      end else if (selectNSync) begin
         readFlags_reg <= 1'b0;
         dataOutOe     <= 1'b0;
      end else if (rxValid && rxFirst) begin
         readFlags_reg <= (rxByte == FLSW_READ_FLAGS_CMD);
         txShift_reg   <= flagsNow;
      end else if (readFlags_reg && sclkFall) begin
         dataOut     <= txShift_reg[7];
         dataOutOe   <= 1'b1;
         txShift_reg <= {txShift_reg[6:0], txShift_reg[7]};
         if (wholeBytes) begin
            txShift_reg <= {flagsNow[6:0], flagsNow[7]};
            dataOut     <= flagsNow[7];
         end
      end
   end
endmodule
`default_nettype wire

// [dv/flsw_checker.sv]
`default_nettype none
module flsw_checker
   import flsw_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire flsw_eng_t  eng,
   input wire flsw_req_t  engReq,
   input wire logic       writeEnableLatch,
   input wire logic       writeInProgress,
   input wire logic [7:0] flagStatus
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   AST_READY_INV: assert property (flagStatus[7] == !$past(writeInProgress))
      else $error("ready bit not inverse of busy");
   AST_RSVD_ZERO: assert property (flagStatus[0] == 1'b0)
      else $error("reserved bit set");
   AST_START_PULSE: assert property (engReq.start |=> !engReq.start)
      else $error("start longer than one cycle");
   AST_START_BUSY: assert property (engReq.start |=> writeInProgress)
      else $error("start without busy");
   AST_START_IDLE: assert property (engReq.start |-> !$past(writeInProgress))
      else $error("start while busy");
   AST_START_WEL: assert property (engReq.start |-> !writeEnableLatch && $past(writeEnableLatch))
      else $error("start without latch or latch kept");
   AST_DONE_IDLE: assert property (eng.done && writeInProgress |=> !writeInProgress)
      else $error("busy after done");
   AST_ERR_TOGETHER: assert property ($fell(flagStatus[5]) || $fell(flagStatus[4])
      || $fell(flagStatus[3]) || $fell(flagStatus[1]) |-> (flagStatus & 8'h3A) == 8'h00)
      else $error("error bits cleared apart");
   AST_SET_BUSY: assert property ($rose(flagStatus[6]) || $rose(flagStatus[2])
      || $rose(flagStatus[3]) |-> $past(writeInProgress, 2))
      else $error("suspend or voltage flag while idle");
   cover property (engReq.start);
   cover property ($rose(flagStatus[6]));
   cover property ($fell(flagStatus[1]));
endmodule
bind flsw_flag_status flsw_checker u_flsw_checker (.clk, .rstn, .eng, .engReq,
   .writeEnableLatch, .writeInProgress, .flagStatus);
`default_nettype wire

// [dv/flsw_host_model.sv]
`default_nettype none
module flsw_host_model (
   input  wire logic dataOutPin,
   output logic      sclkPin,
   output logic      selectNPin,
   output logic      dataInPin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclkPin = 1'b0;
      selectNPin = 1'b1;
      dataInPin = 1'b0;
   end
   // msb first, count chosen by caller
   task automatic frame(input logic [15:0] bits, input int nb, output logic [15:0] got);
      got = '0;
      selectNPin = 1'b0;
      for (int i = 0; i < nb; i++) begin
         dataInPin = bits[15-i];
         #160 sclkPin = 1'b1;
         // reply bit taken on the rise, as a host would
         got[15-i] = dataOutPin;
         #160 sclkPin = 1'b0;
      end
      #160 selectNPin = 1'b1;
      // released line shows no stale bit
      dataInPin = ~dataInPin;
      #480;
   endtask
endmodule
`default_nettype wire

// [dv/flash_flag_status_and_write_latch_tb.sv]
`default_nettype none
module flash_flag_status_and_write_latch_tb
   import flsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wpN = 1'b1;
   logic       vpp = 1'b0;
   logic       initDone = 1'b0;
   logic [1:0] lineMode = 2'h0;
   logic       dataOut;
   logic       dataOutOe;
   wire logic  dataOutPin;
   flsw_prot_t prot = '0;
   flsw_eng_t  eng = '0;
   wire logic  sclkPin, selectNPin, dataInPin, writeEnableLatch, writeInProgress;
   flsw_req_t  engReq;
   logic [7:0] flagStatus;
   int         err_count = 0;
   int         checks = 0;
   int         starts = 0;
   flsw_op_t   lastKind;
   logic [7:0] opTab [12] = '{8'h02, 8'hA2, 8'hD2, 8'h32, 8'h12, 8'h42, 8'h20, 8'hD8, 8'hC7,
                              8'h01, 8'hE5, 8'hB1};
   flsw_op_t   kindTab [12] = '{FLSW_OP_PROGRAM, FLSW_OP_PROGRAM, FLSW_OP_PROGRAM,
      FLSW_OP_PROGRAM, FLSW_OP_PROGRAM, FLSW_OP_OTP, FLSW_OP_ERASE, FLSW_OP_ERASE,
      FLSW_OP_ERASE, FLSW_OP_STATUS_WR, FLSW_OP_LOCK_WR, FLSW_OP_NVCR_WR};
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (engReq.start === 1'b1) begin
         starts++;
         lastKind = engReq.kind;
      end
   end
   // released data line pulled high
   assign dataOutPin = dataOutOe ? dataOut : 1'b1;
   flsw_host_model u_flsw_host_model (.dataOutPin, .sclkPin, .selectNPin, .dataInPin);
   flsw_flag_status u_flsw_flag_status (.clk, .rstn, .sclkPin, .selectNPin, .dataInPin,
      .writeProtectNPin(wpN), .vppHighPin(vpp), .dataOut, .dataOutOe,
      .twoLineProtocol(lineMode[0]), .fourLineProtocol(lineMode[1]), .initDone, .prot, .eng,
      .engReq,
      .writeEnableLatch, .writeInProgress, .flagStatus);
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int nb, input logic [7:0] fs, input logic write_enable_latch);
      logic [15:0] got;
      u_flsw_host_model.frame({op, 8'h5A}, nb, got);
      repeat (4) @(posedge clk);
      #1;
      chk("flagStatus", fs, flagStatus);
      chk("latch", {7'h00, write_enable_latch}, {7'h00, writeEnableLatch});
      if (op == FLSW_READ_FLAGS_CMD) begin
         chk("readback", fs, got[7:0]);
      end
   endtask
   // one-cycle engine report, then let flags land
   task automatic finish(input logic [3:0] e);
      @(posedge clk) #1;
      eng = e;
      @(posedge clk) #1;
      eng = '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      err_count++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk);
      chk("flagStatus", 8'h00, flagStatus);
      #1 initDone = 1'b1;
      repeat (4) @(posedge clk);
      chk("flagStatus", 8'h80, flagStatus);
      cmd(8'h70, 16, 8'h80, 1'b0);
      cmd(8'h06, 8, 8'h80, 1'b1);
      cmd(8'h04, 8, 8'h80, 1'b0);
      cmd(8'h02, 16, 8'h80, 1'b0);
      cmd(8'h06, 8, 8'h80, 1'b1);
      cmd(8'h02, 12, 8'h80, 1'b1);
      chk("starts", 8'h00, starts[7:0]);
      $display("test latch done");
      for (int i = 0; i < 12; i++) begin
         cmd(8'h06, 8, 8'h80, 1'b1);
         cmd(opTab[i], 16, 8'h00, 1'b0);
         chk("kind", {5'h00, kindTab[i]}, {5'h00, lastKind});
         finish(4'h8);
         chk("flagStatus", 8'h80, flagStatus);
      end
      $display("test opcodes done");
      cmd(8'h06, 8, 8'h80, 1'b1);
      cmd(8'h02, 16, 8'h00, 1'b0);
      cmd(8'h75, 8, 8'h04, 1'b0);
      cmd(8'h70, 16, 8'h04, 1'b0);
      cmd(8'h7A, 8, 8'h00, 1'b0);
      finish(4'hC);
      chk("flagStatus", 8'h90, flagStatus);
      cmd(8'h70, 16, 8'h90, 1'b0);
      cmd(8'h06, 8, 8'h90, 1'b1);
      cmd(8'h02, 16, 8'h90, 1'b1);
      cmd(8'h50, 8, 8'h80, 1'b1);
      cmd(8'hD8, 16, 8'h00, 1'b0);
      cmd(8'h75, 8, 8'h40, 1'b0);
      cmd(8'h7A, 8, 8'h00, 1'b0);
      finish(4'hC);
      chk("flagStatus", 8'hA0, flagStatus);
      cmd(8'h06, 8, 8'hA0, 1'b1);
      cmd(8'h20, 16, 8'hA0, 1'b1);
      chk("starts", 8'h0E, starts[7:0]);
      cmd(8'h50, 8, 8'h80, 1'b1);
      #1 prot.sectorLockProtection = 1'b1;
      cmd(8'hD8, 16, 8'hA2, 1'b0);
      cmd(8'h50, 8, 8'h80, 1'b0);
      #1 prot = '{1'b0, 1'b0, 1'b0, 1'b1};
      wpN = 1'b0;
      cmd(8'h06, 8, 8'h80, 1'b1);
      cmd(8'h01, 16, 8'h82, 1'b0);
      cmd(8'h50, 8, 8'h80, 1'b0);
      #1 prot = '0;
      wpN = 1'b1;
      $display("test flags done");
      for (int v = 0; v < 2; v++) begin
         #1 vpp = v[0];
         cmd(8'h06, 8, 8'h80, 1'b1);
         cmd(8'h02, 16, 8'h00, 1'b0);
         finish(4'hB);
         chk("flagStatus", v[0] ? 8'h90 : 8'h80, flagStatus);
         cmd(8'h50, 8, 8'h80, 1'b0);
      end
      cmd(8'h06, 8, 8'h80, 1'b1);
      cmd(8'h02, 16, 8'h00, 1'b0);
      #1 vpp = 1'b0;
      repeat (4) @(posedge clk);
      finish(4'h8);
      chk("flagStatus", 8'h88, flagStatus);
      cmd(8'h06, 8, 8'h88, 1'b1);
      cmd(8'hD8, 16, 8'h88, 1'b1);
      chk("starts", 8'h11, starts[7:0]);
      cmd(8'h50, 8, 8'h80, 1'b1);
      $display("test voltage done");
      for (int m = 1; m < 3; m++) begin
         #1 lineMode = m[1:0];
         cmd(8'h06, 8, 8'h80, 1'b1);
         cmd(8'h32, 16, 8'h80, 1'b1);
         cmd(8'h02, 16, 8'h00, 1'b0);
         finish(4'h8);
         chk("flagStatus", 8'h80, flagStatus);
      end
      chk("starts", 8'h13, starts[7:0]);
      cmd(8'h06, 8, 8'h80, 1'b1);
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("latch", 8'h00, {7'h00, writeEnableLatch});
      chk("flagStatus", 8'h80, flagStatus);
      $display("test modes done");
      end_sim;
   end
endmodule
`default_nettype wire
